// file: rtl/bft_transceiver.sv
`timescale 1ns/1ps
`include "bft_defines.svh"

module bft_transceiver #(
  parameter int CMD_W         = 4,
  parameter int TX_FIFO_DEPTH = 3
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             transceiver_reset,
  // Transmit data and command
  input  wire logic [7:0]       rx_tx_data_reg,
  input  wire logic             data_wr,
  input  wire logic [CMD_W-1:0] tx_command_reg,
  // Mode controls
  input  wire logic             tx_invert,
  input  wire logic             advance_enable,
  input  wire logic             twinax_mode,
  input  wire logic [7:0]       auxiliary_reg,
  input  wire logic             repeater_mode,
  input  wire logic             loopback,
  input  wire logic             line_receiver_select,
  input  wire logic             rx_invert,
  input  wire logic             quiesce_count_select,
  // Status
  output      logic             tx_fifo_empty,
  output      logic             tx_fifo_full,
  output      logic             tx_active_flag,
  output      logic             line_active_flag,
  output      logic             rx_active_flag,
  output      logic             rx_bit,
  output      logic             rx_bit_valid,
  // Line
  output      logic             biphase_out_direct,
  output      logic             biphase_out_delayed,
  output      logic             line_driver_enable,
  input  wire logic             analog_rx_in,
  input  wire logic             serial_rx_in
);
  localparam int WORD_W = 8 + CMD_W;

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  bft_stream_if #(.WIDTH(WORD_W)) in_s ();
  bft_stream_if #(.WIDTH(WORD_W)) out_s ();

  logic fifo_full;
  logic fifo_empty;
  logic pop_go;

  assign in_s.valid  = data_wr;
  assign in_s.data   = {tx_command_reg, rx_tx_data_reg};
  assign out_s.ready = pop_go;

  bft_fifo #(.WIDTH(WORD_W), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .flush (transceiver_reset),
    .wr    (in_s),
    .rd    (out_s),
    .full  (fifo_full),
    .empty (fifo_empty)
  );

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  bft_pkg::bft_tx_state_t st_q, st_d;
  logic [2:0]        ph_q;
  logic [3:0]        idx_q, idx_d;
  logic [4:0]        scnt_q;
  logic [WORD_W-1:0] enc_q;
  logic [WORD_W+1:0] sh_q, sh_d;
  logic              loaded_q, loaded_d;
  logic              more_q, more_d;
  logic              first_q;
  logic              drv_q, drv_d;
  logic [6:0]        hold_q, hold_d;
  logic              lvl_q, lvl_d;
  logic              dly_q;

  wire tx_on     = (st_q != bft_pkg::TX_IDLE);
  wire bit_end   = (ph_q == `BFT_PH_LAST);
  wire first_hlf = (ph_q < `BFT_PH_HALF);
  wire [2:0] qui_last = (advance_enable ? `BFT_QUI_BITS_AD : `BFT_QUI_BITS) - 3'h1;
  wire load_tick = loaded_q ? 1'b0 : (scnt_q == `BFT_TX_LOAD_CYC - 5'h01);
  wire last_par  = (st_q == bft_pkg::TX_FRAME) && (idx_q == `BFT_FRAME_LAST) && !twinax_mode;
  wire last_fill = (st_q == bft_pkg::TX_FILL) && (idx_q == `BFT_FILL_LAST);
  wire last_start = (ph_q == 3'h0) && (last_par || last_fill);
  wire [WORD_W+1:0] frame_ld = {1'b1, enc_q, ^{1'b1, enc_q}};
  wire [4:0] hold_half = auxiliary_reg[`BFT_HOLD_MSB:`BFT_HOLD_LSB];

  assign pop_go = (load_tick || last_start) && out_s.valid && tx_on;

  // Bit sequencer
  always_comb
  begin
    st_d     = st_q;
    idx_d    = idx_q;
    sh_d     = sh_q;
    loaded_d = loaded_q;
    more_d   = more_q;
    drv_d    = drv_q;
    hold_d   = hold_q;
    lvl_d    = 1'b0;
    if (pop_go) begin
      loaded_d = 1'b1;
      more_d   = last_start;
    end
    case (st_q)
      bft_pkg::TX_IDLE:
      begin
        loaded_d = 1'b0;
        more_d   = 1'b0;
        drv_d    = 1'b0;
        idx_d    = 4'h0;
        if (data_wr) begin
          st_d  = bft_pkg::TX_QUIESCE;
          drv_d = !advance_enable;
        end
      end
      bft_pkg::TX_QUIESCE:
      begin
        lvl_d = first_hlf ? 1'b0 : 1'b1;
        if (first_q && (ph_q == `BFT_PH_DRV_ADV))
          drv_d = 1'b1;
        if (bit_end) begin
          idx_d = idx_q + 4'h1;
          if (idx_q == {1'b0, qui_last}) begin
            st_d  = bft_pkg::TX_VIOL;
            idx_d = 4'h0;
          end
        end
      end
      bft_pkg::TX_VIOL:
      begin
        lvl_d = 1'b1;
        if (bit_end) begin
          st_d  = loaded_q ? bft_pkg::TX_FRAME : bft_pkg::TX_END;
          sh_d  = frame_ld;
          idx_d = 4'h0;
        end
      end
      bft_pkg::TX_FRAME:
      begin
        lvl_d = first_hlf ? !sh_q[WORD_W+1] : sh_q[WORD_W+1];
        if (bit_end) begin
          sh_d  = {sh_q[WORD_W:0], 1'b0};
          idx_d = idx_q + 4'h1;
          if (idx_q == `BFT_FRAME_LAST) begin
            idx_d = 4'h0;
            sh_d  = frame_ld;
            if (twinax_mode)
              st_d = bft_pkg::TX_FILL;
            else if (more_q)
              more_d = 1'b0;
            else
              st_d = bft_pkg::TX_END;
          end
        end
      end
      bft_pkg::TX_FILL:
      begin
        lvl_d = first_hlf ? 1'b1 : 1'b0;
        if (bit_end) begin
          idx_d = idx_q + 4'h1;
          if (idx_q == `BFT_FILL_LAST) begin
            idx_d  = 4'h0;
            sh_d   = frame_ld;
            more_d = 1'b0;
            hold_d = {hold_half, 2'b00};
            if (more_q)
              st_d = bft_pkg::TX_FRAME;
            else if (hold_half == 5'h00)
              st_d = bft_pkg::TX_IDLE;
            else
              st_d = bft_pkg::TX_HOLD;
          end
        end
      end
      bft_pkg::TX_HOLD:
      begin
        lvl_d  = lvl_q;
        hold_d = hold_q - 7'h01;
        if (hold_q == 7'h01)
          st_d = bft_pkg::TX_IDLE;
      end
      default:
      begin
        lvl_d = first_hlf;
        if (bit_end)
          st_d = bft_pkg::TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      st_q     <= bft_pkg::TX_IDLE;
      ph_q     <= 3'h0;
      idx_q    <= 4'h0;
      scnt_q   <= 5'h00;
      enc_q    <= '0;
      sh_q     <= '0;
      loaded_q <= 1'b0;
      more_q   <= 1'b0;
      first_q  <= 1'b0;
      drv_q    <= 1'b0;
      hold_q   <= 7'h00;
      lvl_q    <= 1'b0;
      dly_q    <= 1'b0;
    end else if (transceiver_reset) begin
      st_q     <= bft_pkg::TX_IDLE;
      ph_q     <= 3'h0;
      loaded_q <= 1'b0;
      drv_q    <= 1'b0;
      lvl_q    <= 1'b0;
      dly_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      ph_q     <= tx_on ? ph_q + 3'h1 : 3'h0;
      idx_q    <= idx_d;
      scnt_q   <= tx_on ? scnt_q + {4'h0, !loaded_q} : 5'h00;
      sh_q     <= sh_d;
      loaded_q <= loaded_d;
      more_q   <= more_d;
      first_q  <= tx_on ? (first_q && !bit_end) : advance_enable;
      drv_q    <= drv_d;
      hold_q   <= hold_d;
      lvl_q    <= lvl_d;
      dly_q    <= (first_q && first_hlf) ? lvl_d : lvl_q;
      if (pop_go)
        enc_q <= out_s.data;
    end
  end

  // Biphase outputs rest at the reset pattern whenever idle; driver enable stays set through the first idle cycle
  assign biphase_out_direct  = (tx_on ? lvl_q : advance_enable) ^ tx_invert;
  assign biphase_out_delayed = (tx_on ? dly_q : 1'b0) ^ tx_invert;
  assign line_driver_enable  = drv_q && !loopback;

  // ----------------------------------------
  // Receiver front-end
  // ----------------------------------------
  bft_pkg::bft_rx_state_t rs_q, rs_d;
  logic       rs_q_in;
  logic       prev_q;
  logic [3:0] rph_q;
  logic       lock_q;
  logic [1:0] qcnt_q, qcnt_d;
  logic [1:0] ra_q, ra_d;
  logic       la_raw;

  wire rx_sel   = loopback ? lvl_q
                : (line_receiver_select ? analog_rx_in : serial_rx_in);
  wire rx_en    = !(tx_on && !repeater_mode);
  wire edge_now = rs_q_in ^ prev_q;
  wire mid_edge = edge_now && (lock_q ? (rph_q >= `BFT_RX_WIN_LO) : rs_q_in);
  wire lost     = lock_q && (rph_q == `BFT_RX_LOST);
  wire [1:0] qneed = quiesce_count_select ? `BFT_QUI_NEED_HI : `BFT_QUI_NEED_LO;

  bft_line_activity #(.TIMEOUT(`BFT_ACT_TIMEOUT)) u_activity (
    .clk       (clk),
    .rst_n     (rst_n),
    .clr       (transceiver_reset),
    .edge_seen (edge_now),
    .active    (la_raw)
  );

  // Start hunt
  always_comb
  begin
    rs_d   = rs_q;
    qcnt_d = qcnt_q;
    ra_d   = 2'h0;
    case (rs_q)
      bft_pkg::RX_HUNT:
      begin
        if (mid_edge)
          qcnt_d = (rs_q_in && (qcnt_q != 2'h3)) ? qcnt_q + 2'h1 : (rs_q_in ? qcnt_q : 2'h0);
        else if (lost) begin
          qcnt_d = 2'h0;
          if (rs_q_in && (qcnt_q >= qneed))
            rs_d = bft_pkg::RX_SYNC;
        end
      end
      bft_pkg::RX_SYNC:
      begin
        if (mid_edge)
          rs_d = rs_q_in ? bft_pkg::RX_ARM : bft_pkg::RX_HUNT;
      end
      bft_pkg::RX_ARM:
      begin
        ra_d = ra_q + 2'h1;
        if (ra_q == `BFT_RA_DELAY - 2'h2)
          rs_d = bft_pkg::RX_ACTIVE;
      end
      default:
      begin
        if (lost)
          rs_d = bft_pkg::RX_HUNT;
      end
    endcase
    if (!rx_en)
    begin
      rs_d   = bft_pkg::RX_HUNT;
      qcnt_d = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      rs_q    <= bft_pkg::RX_HUNT;
      rs_q_in <= 1'b0;
      prev_q  <= 1'b0;
      rph_q   <= `BFT_RX_PH_MAX;
      lock_q  <= 1'b0;
      qcnt_q  <= 2'h0;
      ra_q    <= 2'h0;
    end else if (transceiver_reset) begin
      rs_q   <= bft_pkg::RX_HUNT;
      lock_q <= 1'b0;
      qcnt_q <= 2'h0;
    end else begin
      rs_q    <= rs_d;
      rs_q_in <= rx_sel ^ rx_invert;
      prev_q  <= rs_q_in;
      rph_q   <= mid_edge ? 4'h0 : ((rph_q == `BFT_RX_PH_MAX) ? rph_q : rph_q + 4'h1);
      lock_q  <= rx_en && (mid_edge || (lock_q && !lost));
      qcnt_q  <= qcnt_d;
      ra_q    <= ra_d;
    end
  end

  // ----------------------------------------
  // Registered status
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      tx_fifo_empty    <= 1'b1;
      tx_fifo_full     <= 1'b0;
      tx_active_flag   <= 1'b0;
      line_active_flag <= 1'b0;
      rx_active_flag   <= 1'b0;
      rx_bit           <= 1'b0;
      rx_bit_valid     <= 1'b0;
    end else begin
      tx_fifo_empty    <= fifo_empty;
      tx_fifo_full     <= fifo_full;
      tx_active_flag   <= tx_on;
      line_active_flag <= la_raw;
      rx_active_flag   <= (rs_q == bft_pkg::RX_ACTIVE);
      rx_bit           <= rs_q_in;
      rx_bit_valid     <= mid_edge && (rs_q == bft_pkg::RX_ACTIVE);
    end
  end
endmodule : bft_transceiver

// file: rtl/bft_defines.svh
`ifndef BFT_DEFINES_SVH
`define BFT_DEFINES_SVH

// ----------------------------------------
// Clock and bit timing
// ----------------------------------------
`define BFT_CLK_NS      100
`define BFT_PH_LAST     3'h7
`define BFT_PH_HALF     3'h4
`define BFT_PH_DRV_ADV  3'h3

// ----------------------------------------
// Transmit sequencing
// ----------------------------------------
`define BFT_TX_LOAD_CYC 5'h10
`define BFT_QUI_BITS    3'h5
`define BFT_QUI_BITS_AD 3'h6
`define BFT_FRAME_LAST  4'hD
`define BFT_FILL_LAST   4'h2
`define BFT_HOLD_LSB    3
`define BFT_HOLD_MSB    7

// ----------------------------------------
// Receive front-end
// ----------------------------------------
`define BFT_ACT_TIMEOUT 16
`define BFT_RX_WIN_LO   4'h6
`define BFT_RX_LOST     4'hA
`define BFT_RX_PH_MAX   4'hF
`define BFT_RA_DELAY    2'h3
`define BFT_QUI_NEED_HI 2'h3
`define BFT_QUI_NEED_LO 2'h2

`endif

// file: rtl/bft_pkg.sv
package bft_pkg;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_QUIESCE,
    TX_VIOL,
    TX_FRAME,
    TX_FILL,
    TX_HOLD,
    TX_END
  } bft_tx_state_t;

  typedef enum logic [1:0] {
    RX_HUNT,
    RX_SYNC,
    RX_ARM,
    RX_ACTIVE
  } bft_rx_state_t;

endpackage : bft_pkg

// file: rtl/bft_stream_if.sv
`timescale 1ns/1ps

interface bft_stream_if #(
  parameter int WIDTH = 12
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : bft_stream_if

// file: rtl/bft_fifo.sv
`timescale 1ns/1ps

module bft_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic flush,
  // Streams
  bft_stream_if.snk wr,
  bft_stream_if.src rd,
  // Status
  output      logic full,
  output      logic empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;

  wire            pop     = rd.valid && rd.ready;
  wire            push    = wr.valid && (!full || pop);
  wire            ovr     = wr.valid && full && !pop;
  wire [AW-1:0]   wr_nxt  = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
  wire [AW-1:0]   rd_nxt  = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
  wire [AW-1:0]   wr_last = (wr_ptr_q == '0) ? AW'(DEPTH - 1) : wr_ptr_q - 1'b1;
  wire [AW-1:0]   wr_slot = ovr ? wr_last : wr_ptr_q;

  assign full     = (cnt_q == (AW + 1)'(DEPTH));
  assign empty    = (cnt_q == '0);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem_q[rd_ptr_q];

  // ----------------------------------------
  // Storage, full write replaces newest word
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (push || ovr)
      mem_q[wr_slot] <= wr.data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else if (flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end else begin
      if (push)
        wr_ptr_q <= wr_nxt;
      if (pop)
        rd_ptr_q <= rd_nxt;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : bft_fifo

// file: rtl/bft_line_activity.sv
`timescale 1ns/1ps

module bft_line_activity #(
  parameter int TIMEOUT = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clr,
  // Line
  input  wire logic edge_seen,
  output      logic active
);
  localparam int CW = $clog2(TIMEOUT + 1);

  logic [CW-1:0] quiet_q;
  logic          active_q;

  wire timed_out = (quiet_q == CW'(TIMEOUT - 1));

  assign active = active_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) begin
      quiet_q  <= '0;
      active_q <= 1'b0;
    end else if (clr) begin
      quiet_q  <= '0;
      active_q <= 1'b0;
    end else if (edge_seen) begin
      quiet_q  <= '0;
      active_q <= 1'b1;
    end else if (active_q) begin
      quiet_q  <= timed_out ? '0 : quiet_q + 1'b1;
      active_q <= !timed_out;
    end
  end
endmodule : bft_line_activity

// file: test/bft_transceiver_sva.sv
`timescale 1ns/1ps

module bft_transceiver_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic transceiver_reset,
  // Controls
  input wire logic data_wr,
  input wire logic tx_invert,
  input wire logic advance_enable,
  input wire logic repeater_mode,
  input wire logic loopback,
  input wire logic line_receiver_select,
  input wire logic rx_invert,
  // Status
  input wire logic tx_fifo_empty,
  input wire logic tx_fifo_full,
  input wire logic tx_active_flag,
  input wire logic line_active_flag,
  input wire logic rx_active_flag,
  // Line
  input wire logic biphase_out_direct,
  input wire logic biphase_out_delayed,
  input wire logic line_driver_enable,
  input wire logic analog_rx_in,
  input wire logic serial_rx_in
);
  // ----------------------------------------
  // Quiet line counter
  // ----------------------------------------
  logic [6:0] in_q;
  logic [4:0] quiet_q;
  logic [4:0] quiet_d;
  wire  [6:0] in_now = {serial_rx_in, analog_rx_in, rx_invert, line_receiver_select,
                        loopback, tx_invert, biphase_out_direct};

  assign quiet_d = (in_now != in_q) ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1F};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_q    <= 7'h00;
      quiet_q <= 5'h00;
    end
    else
    begin
      in_q    <= in_now;
      quiet_q <= quiet_d;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence load_idle_s;
    tx_fifo_empty && !tx_active_flag && data_wr && !transceiver_reset;
  endsequence

  sequence start_s;
    (line_driver_enable || advance_enable || loopback) ##1 (tx_active_flag && !tx_fifo_empty);
  endsequence

  reset_drive_a: assert property (transceiver_reset[*2] |=> !line_driver_enable)
    else $error("driver enable high after soft reset");
  reset_level_a: assert property (transceiver_reset[*2] |=>
    biphase_out_delayed == tx_invert && biphase_out_direct == (tx_invert ^ advance_enable))
    else $error("biphase rest levels wrong under soft reset");
  tx_start_a: assert property (load_idle_s |-> ##[1:2] start_s)
    else $error("transmitter did not start after first load");
  fifo_full_a: assert property (load_idle_s ##1 (data_wr && !transceiver_reset)[*2]
    |-> ##[1:2] tx_fifo_full)
    else $error("full flag missing after three loads");
  delay_follow_a: assert property (line_driver_enable && $past(line_driver_enable)
    && !advance_enable && $stable(tx_invert) |-> biphase_out_delayed == $past(biphase_out_direct))
    else $error("delayed output does not trail direct output");
  half_bit_a: assert property (line_driver_enable && $changed(biphase_out_direct)
    |=> ($stable(biphase_out_direct) || !line_driver_enable || $changed(tx_invert))[*3])
    else $error("biphase half bit shorter than four cycles");
  act_rise_a: assert property (!transceiver_reset && !loopback && !line_receiver_select
    && $changed(serial_rx_in) && $stable(line_receiver_select) && $stable(rx_invert)
    |-> ##[1:3] line_active_flag)
    else $error("line active did not follow an input edge");
  act_fall_a: assert property (quiet_q == 5'h14 |-> !line_active_flag)
    else $error("line active held on a quiet line");
  half_duplex_a: assert property ((tx_active_flag && !repeater_mode)[*4] |-> !rx_active_flag)
    else $error("receiver active while transmitting half duplex");
  loop_drive_a: assert property (loopback && $past(loopback) |-> !line_driver_enable)
    else $error("driver enable high in loopback");
endmodule : bft_transceiver_sva

bind bft_transceiver bft_transceiver_sva bft_transceiver_sva_inst (
  .clk(clk), .rst_n(rst_n), .transceiver_reset(transceiver_reset), .data_wr(data_wr),
  .tx_invert(tx_invert), .advance_enable(advance_enable), .repeater_mode(repeater_mode),
  .loopback(loopback), .line_receiver_select(line_receiver_select), .rx_invert(rx_invert),
  .tx_fifo_empty(tx_fifo_empty), .tx_fifo_full(tx_fifo_full), .tx_active_flag(tx_active_flag),
  .line_active_flag(line_active_flag), .rx_active_flag(rx_active_flag),
  .biphase_out_direct(biphase_out_direct), .biphase_out_delayed(biphase_out_delayed),
  .line_driver_enable(line_driver_enable), .analog_rx_in(analog_rx_in),
  .serial_rx_in(serial_rx_in)
);

// file: test/bft_line_model.sv
`timescale 1ns/1ps

module bft_line_model (
  // Clock
  input  wire logic clk,
  // Block transmit side
  input  wire logic driver_en,
  input  wire logic line_in,
  // Block receive side
  output      logic line_out
);
  logic       seen[$];
  logic [2:0] phase_q = 3'h0;

  // ----------------------------------------
  // Decode driven bits late in second half
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!driver_en)
      phase_q <= 3'h0;
    else
    begin
      if (phase_q == 3'h6)
        seen.push_back(line_in);
      phase_q <= phase_q + 3'h1;
    end
  end

  // ----------------------------------------
  // Line source, terminated low when quiet
  // ----------------------------------------
  initial line_out = 1'b0;

  task automatic put_bit(input logic b);
    line_out = ~b;
    repeat (4) @(negedge clk);
    line_out = b;
    repeat (4) @(negedge clk);
  endtask : put_bit

  task automatic send_start(input int quiesce);
    repeat (quiesce) put_bit(1'b1);
    line_out = 1'b1;
    repeat (8) @(negedge clk);
    put_bit(1'b1);
    line_out = 1'b0;
  endtask : send_start
endmodule : bft_line_model

// file: test/test_bft_transceiver.sv
`timescale 1ns/1ps

`define BFT_CHECK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module test_bft_transceiver;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       clk = 1'b0, rst_n = 1'b0, transceiver_reset = 1'b0, data_wr = 1'b0;
  logic [7:0] rx_tx_data_reg = 8'h00, auxiliary_reg = 8'h00;
  logic [3:0] tx_command_reg = 4'h0;
  logic       tx_invert = 1'b0, advance_enable = 1'b0, twinax_mode = 1'b0;
  logic       repeater_mode = 1'b0, loopback = 1'b0, line_receiver_select = 1'b1;
  logic       rx_invert = 1'b0, quiesce_count_select = 1'b1, route_analog = 1'b1;
  logic       tx_fifo_empty, tx_fifo_full, tx_active_flag, line_active_flag;
  logic       rx_active_flag, rx_bit, rx_bit_valid, m_line;
  logic       biphase_out_direct, biphase_out_delayed, line_driver_enable;
  wire  logic analog_rx_in = route_analog & m_line;
  wire  logic serial_rx_in = ~route_analog & m_line;
  int         mismatches = 0, tests_run = 0;

  always #50 clk = ~clk;

  bft_transceiver bft_transceiver_inst (
    .clk(clk), .rst_n(rst_n), .transceiver_reset(transceiver_reset),
    .rx_tx_data_reg(rx_tx_data_reg), .data_wr(data_wr), .tx_command_reg(tx_command_reg),
    .tx_invert(tx_invert), .advance_enable(advance_enable), .twinax_mode(twinax_mode),
    .auxiliary_reg(auxiliary_reg), .repeater_mode(repeater_mode), .loopback(loopback),
    .line_receiver_select(line_receiver_select), .rx_invert(rx_invert),
    .quiesce_count_select(quiesce_count_select), .tx_fifo_empty(tx_fifo_empty),
    .tx_fifo_full(tx_fifo_full), .tx_active_flag(tx_active_flag),
    .line_active_flag(line_active_flag), .rx_active_flag(rx_active_flag), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .biphase_out_direct(biphase_out_direct),
    .biphase_out_delayed(biphase_out_delayed), .line_driver_enable(line_driver_enable),
    .analog_rx_in(analog_rx_in), .serial_rx_in(serial_rx_in)
  );

  bft_line_model bft_line_model_inst (
    .clk(clk), .driver_en(line_driver_enable), .line_in(biphase_out_direct), .line_out(m_line)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wr(input logic [11:0] w, input logic last);
    tx_command_reg = w[11:8];
    rx_tx_data_reg = w[7:0];
    data_wr = 1'b1;
    @(negedge clk);
    if (last)
      data_wr = 1'b0;
  endtask : wr

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    while (tx_active_flag === 1'b1 && n < 900)
    begin
      @(negedge clk);
      n++;
    end
    `BFT_CHECK("active after message", 1'b0, tx_active_flag)
    `BFT_CHECK("driver after message", 1'b0, line_driver_enable)
    `BFT_CHECK("empty after message", 1'b1, tx_fifo_empty)
  endtask : wait_idle

  task automatic check_frame(input int at, input logic [11:0] w);
    logic [12:0] f;
    f = {1'b1, w};
    for (int i = 0; i < 13; i++)
      `BFT_CHECK("frame bit", f[12-i], bft_line_model_inst.seen[at+i])
    `BFT_CHECK("parity bit", ^f, bft_line_model_inst.seen[at+13])
  endtask : check_frame

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    advance_enable = 1'b1;
    tx_invert = 1'b1;
    transceiver_reset = 1'b1;
    repeat (2) @(negedge clk);
    `BFT_CHECK("delayed rest", 1'b1, biphase_out_delayed)
    `BFT_CHECK("direct rest", 1'b0, biphase_out_direct)
    transceiver_reset = 1'b0;
    @(negedge clk);
    `BFT_CHECK("empty rest", 1'b1, tx_fifo_empty)
    `BFT_CHECK("full rest", 1'b0, tx_fifo_full)
    tx_invert = 1'b0;
    #1;
    `BFT_CHECK("delayed invert", 1'b0, biphase_out_delayed)
    `BFT_CHECK("direct invert", 1'b1, biphase_out_direct)
    advance_enable = 1'b0;
    @(negedge clk);
    $display("test reset done");
  endtask : t_reset

  task automatic t_single();
    bft_line_model_inst.seen.delete();
    wr(12'h3A5, 1'b1);
    wait_idle();
    for (int i = 0; i < 6; i++)
      `BFT_CHECK("quiesce bit", 1'b1, bft_line_model_inst.seen[i])
    check_frame(6, 12'h3A5);
    $display("test single frame done");
  endtask : t_single

  task automatic t_fill();
    bft_line_model_inst.seen.delete();
    wr(12'h15A, 1'b0);
    wr(12'h2C3, 1'b0);
    wr(12'h0F0, 1'b1);
    repeat (2) @(negedge clk);
    `BFT_CHECK("full after three", 1'b1, tx_fifo_full)
    wr(12'h481, 1'b1);
    repeat (8) @(negedge clk);
    `BFT_CHECK("full before take", 1'b1, tx_fifo_full)
    repeat (10) @(negedge clk);
    `BFT_CHECK("full after take", 1'b0, tx_fifo_full)
    wait_idle();
    check_frame(6, 12'h15A);
    check_frame(20, 12'h2C3);
    check_frame(34, 12'h481);
    $display("test fill done");
  endtask : t_fill

  task automatic t_twinax();
    int len[2];
    twinax_mode = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      auxiliary_reg = k ? 8'hFF : 8'h07;
      bft_line_model_inst.seen.delete();
      wr(12'h155, 1'b1);
      len[k] = 0;
      repeat (2) @(negedge clk);
      while (tx_active_flag === 1'b1 && len[k] < 900)
      begin
        @(negedge clk);
        len[k]++;
      end
      check_frame(6, 12'h155);
      for (int i = 20; i < 23; i++)
        `BFT_CHECK("fill bit", 1'b0, bft_line_model_inst.seen[i])
    end
    `BFT_CHECK("hold cycles", (8'hFF >> 3) * 4, len[1] - len[0])
    twinax_mode = 1'b0;
    auxiliary_reg = 8'h00;
    $display("test twinax done");
  endtask : t_twinax

  task automatic t_rx();
    int         nq[4] = '{2, 4, 3, 4};
    logic [3:0] qs = 4'b1011;
    logic [3:0] sel = 4'b1011;
    logic [3:0] rt = 4'b0011;
    logic [3:0] la = 4'b0111;
    logic [3:0] ra = 4'b0110;
    for (int k = 0; k < 4; k++)
    begin
      quiesce_count_select = qs[k];
      line_receiver_select = sel[k];
      route_analog = rt[k];
      repeat (2) @(negedge clk);
      bft_line_model_inst.send_start(nq[k]);
      `BFT_CHECK("line active", la[k], line_active_flag)
      @(negedge clk);
      `BFT_CHECK("rx active", ra[k], rx_active_flag)
      repeat (30) @(negedge clk);
      `BFT_CHECK("line quiet", 1'b0, line_active_flag)
    end
    rx_invert = 1'b1;
    repeat (3) @(negedge clk);
    `BFT_CHECK("line active invert", 1'b1, line_active_flag)
    rx_invert = 1'b0;
    route_analog = 1'b1;
    repeat (30) @(negedge clk);
    $display("test receive start done");
  endtask : t_rx

  task automatic t_duplex();
    logic got_ra;
    int   nbv = 0, n1 = 0;
    wr(12'h0C3, 1'b1);
    bft_line_model_inst.send_start(4);
    `BFT_CHECK("line active in tx", 1'b1, line_active_flag)
    `BFT_CHECK("rx off in tx", 1'b0, rx_active_flag)
    wait_idle();
    repeater_mode = 1'b1;
    loopback = 1'b1;
    got_ra = 1'b0;
    wr(12'h0C3, 1'b1);
    repeat (200)
    begin
      @(negedge clk);
      got_ra |= (rx_active_flag === 1'b1);
      nbv += (rx_bit_valid === 1'b1);
      n1 += (rx_bit_valid === 1'b1 && rx_bit === 1'b1);
    end
    `BFT_CHECK("loopback rx active", 1'b1, got_ra)
    `BFT_CHECK("decoded bits", 14, nbv)
    `BFT_CHECK("decoded ones", 5, n1)
    wait_idle();
    loopback = 1'b0;
    repeater_mode = 1'b0;
    $display("test duplex done");
  endtask : t_duplex

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    #2000000;
    mismatches++;
    complete_run();
  end

  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_single();
    t_fill();
    t_twinax();
    t_rx();
    t_duplex();
    complete_run();
  end
endmodule : test_bft_transceiver
